// ### hw/gphy_np_defines.svh
// register map, field positions, reset values and frame constants
`ifndef GPHY_NP_DEFINES_SVH
`define GPHY_NP_DEFINES_SVH

// register addresses on the management link
`define RA_EXPANSION 5'h06
`define RA_NP_TX     5'h07
`define RA_LP_NP     5'h08
`define RA_GB_CTRL   5'h09
`define RA_GB_STAT   5'h0a

// next page word fields
`define NP_NEXT      15
`define NP_MSG       13
`define NP_ACK2      12
`define NP_TOGGLE    11
`define NP_TX_RST    16'h23ff
`define NP_TX_WMASK  16'hb7ff

// gigabit control fields
`define CTRL_TM_HI   15
`define CTRL_TM_LO   13
`define CTRL_MS_MAN  12
`define CTRL_MS_VAL  11
`define CTRL_PORT    10
`define CTRL_ADV_FD  9
`define CTRL_ADV_HD  8
`define CTRL_WMASK   16'hff00
`define CTRL_RST     16'h0000
`define TM_MAX       3'h4
`define TM_NORMAL    3'h0

// gigabit status and expansion fields
`define IDLE_MAX     8'hff
`define EXP_PAGE_RX  1

// serial frame
`define OP_READ      2'b10
`define OP_WRITE     2'b01
`define HDR_LAST     5'h0c
`define DATA_LAST    5'h0f
`define FRAME_LAST   6'h1f
`define RD_RELEASE   6'h0e
`define RD_SAMPLE    6'h10

// station controller registers
`define HA_CMD       2'h0
`define HA_WDATA     2'h1
`define HA_RDATA     2'h2
`define HA_STAT      2'h3
`define CMD_WRITE    10

`endif

// ### hw/gphy_np_pkg.sv
// state types for the two ends of the management link, one enum for each end
package gphy_np_pkg;
  typedef enum logic [3:0] {
    F_IDLE = 4'b0001,
    F_HDR  = 4'b0010,
    F_TA   = 4'b0100,
    F_DATA = 4'b1000
  } frame_state_t;
  typedef enum logic [2:0] {
    H_IDLE  = 3'b001,
    H_PRE   = 3'b010,
    H_FRAME = 3'b100
  } sta_state_t;
endpackage

// ### hw/mgmt_serial_if.sv
// management serial link between station controller and phy
`timescale 1ns/1ps
interface mgmt_serial_if;
  logic mdc;
  logic mdio_h_out;
  logic mdio_h_oe;
  logic mdio_d_out;
  logic mdio_d_oe;
  logic mdio;
  // wired data line, pulled high when nobody drives
  assign mdio = mdio_h_oe ? mdio_h_out : (mdio_d_oe ? mdio_d_out : 1'b1);
  modport phy_end (input mdc, input mdio, output mdio_d_out, output mdio_d_oe);
  modport sta_end (output mdc, output mdio_h_out, output mdio_h_oe, input mdio);
endinterface

// ### hw/gphy_np_regs.sv
// phy end: serial frame decoder and gigabit next page register bank
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "gphy_np_defines.svh"
module gphy_np_regs
  import gphy_np_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  mgmt_serial_if.phy_end   mgmt,
  input  wire logic        ms_fault_in,
  input  wire logic        ms_master_in,
  input  wire logic        local_rx_ok_in,
  input  wire logic        remote_rx_ok_in,
  input  wire logic        lp_1000fd_in,
  input  wire logic        lp_1000hd_in,
  input  wire logic        idle_err_in,
  input  wire logic        an_complete_in,
  input  wire logic        an_start_in,
  input  wire logic        base_toggle_in,
  input  wire logic        page_sent_in,
  input  wire logic        page_rx_in,
  input  wire logic [15:0] page_word_in,
  output logic      [2:0]  test_mode_out,
  output logic             ms_manual_out,
  output logic             ms_cfg_master_out,
  output logic             port_multi_out,
  output logic             adv_1000fd_out,
  output logic             adv_1000hd_out,
  output logic      [4:0]  tech_ext_out,
  output logic      [15:0] np_tx_out,
  output logic             page_rx_flag_out
);

  frame_state_t state_r;
  logic         mdc_q_r;
  logic [4:0]   cnt_r;
  logic [12:0]  hdr_r;
  logic [15:0]  dat_r;
  logic         d_out_r;
  logic         d_oe_r;
  logic [15:0]  np_tx_r;
  logic [15:0]  lp_np_r;
  logic [15:0]  ctrl_r;
  logic [2:0]   tm_r;
  logic         cfg_master_r;
  logic         fault_r;
  logic [4:0]   live_r;
  logic [7:0]   idle_cnt_r;
  logic         page_flag_r;

  logic         rise;
  logic         mine;
  logic         is_rd;
  logic         is_wr;
  logic         rd_now;
  logic         wr_now;
  logic [4:0]   ra;
  logic [15:0]  wr_word;
  logic         rd_stat;
  logic         rd_exp;
  logic         idle_hit;

  // read view of every mapped register; unmapped addresses read zero
  function automatic logic [15:0] rd_mux(input logic [4:0] a);
    logic [15:0] v;
    v = 16'h0000;
    case (a)
      `RA_EXPANSION: v[`EXP_PAGE_RX] = page_flag_r;
      `RA_NP_TX:     v = np_tx_r;
      `RA_LP_NP:     v = lp_np_r;
      `RA_GB_CTRL:   v = ctrl_r;
      `RA_GB_STAT:   v = {fault_r, live_r, 2'b00, idle_cnt_r};
      default:       v = 16'h0000;
    endcase
    return v;
  endfunction

  // mdc is synchronous to our clock, so a one-flop history finds its rise
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      mdc_q_r <= 1'b0;
    end else begin
      mdc_q_r <= mgmt.mdc;
    end
  end

  assign rise    = mgmt.mdc & ~mdc_q_r;
  assign ra      = hdr_r[4:0];
  assign mine    = hdr_r[12] & (hdr_r[9:5] == PHY_ADDR);
  assign is_rd   = mine & (hdr_r[11:10] == `OP_READ);
  assign is_wr   = mine & (hdr_r[11:10] == `OP_WRITE);
  // the register is read when turnaround starts, written on the last data bit
  assign rd_now  = rise & (state_r == F_TA) & (cnt_r == 5'h00) & is_rd;
  assign wr_now  = rise & (state_r == F_DATA) & (cnt_r == `DATA_LAST) & is_wr;
  assign wr_word = {dat_r[14:0], mgmt.mdio};
  assign rd_stat = rd_now & (ra == `RA_GB_STAT);
  assign rd_exp  = rd_now & (ra == `RA_EXPANSION);

  // frame walk: start bit low, 13 header bits, 2 turnaround, 16 data
  // frames for another address are walked to the end but ignored
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state_r <= F_IDLE;
      cnt_r   <= 5'h00;
      hdr_r   <= 13'h0000;
    end else if (rise) begin
      unique case (state_r)
        F_IDLE: begin
          cnt_r <= 5'h00;
          if (!mgmt.mdio) begin
            state_r <= F_HDR;
          end
        end
        F_HDR: begin
          hdr_r <= {hdr_r[11:0], mgmt.mdio};
          cnt_r <= cnt_r + 5'h01;
          if (cnt_r == `HDR_LAST) begin
            state_r <= F_TA;
            cnt_r   <= 5'h00;
          end
        end
        F_TA: begin
          cnt_r <= cnt_r + 5'h01;
          if (cnt_r == 5'h01) begin
            state_r <= F_DATA;
            cnt_r   <= 5'h00;
          end
        end
        F_DATA: begin
          cnt_r <= cnt_r + 5'h01;
          if (cnt_r == `DATA_LAST) begin
            state_r <= F_IDLE;
            cnt_r   <= 5'h00;
          end
        end
      endcase
    end
  end

  // data shifter and line drive; we drive only on our own read frames
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      dat_r   <= 16'h0000;
      d_out_r <= 1'b0;
      d_oe_r  <= 1'b0;
    end else if (rise) begin
      if (rd_now) begin
        dat_r   <= rd_mux(ra);
        d_out_r <= 1'b0;   // second turnaround bit low
        d_oe_r  <= 1'b1;
      end else if (state_r == F_TA && cnt_r == 5'h01) begin
        d_out_r <= dat_r[15];
        dat_r   <= {dat_r[14:0], 1'b0};
      end else if (state_r == F_DATA) begin
        d_out_r <= d_oe_r ? dat_r[15] : 1'b0;
        dat_r   <= wr_word;
        if (cnt_r == `DATA_LAST) begin
          d_oe_r <= 1'b0;
        end
      end
    end
  end

  assign mgmt.mdio_d_out = d_out_r;
  assign mgmt.mdio_d_oe  = d_oe_r;

  // next page to send; toggle is ours, bit 14 stays zero, the rest is software's
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      np_tx_r <= `NP_TX_RST;
    end else begin
      if (wr_now && ra == `RA_NP_TX) begin
        np_tx_r <= (wr_word & `NP_TX_WMASK) | (np_tx_r & ~`NP_TX_WMASK);
      end
      if (an_start_in) begin
        np_tx_r[`NP_TOGGLE] <= ~base_toggle_in;
      end else if (page_sent_in) begin
        np_tx_r[`NP_TOGGLE] <= ~np_tx_r[`NP_TOGGLE];
      end
    end
  end

  assign np_tx_out = np_tx_r;

  // received next page and its arrival flag; a new page beats a read clear
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      lp_np_r     <= 16'h0000;
      page_flag_r <= 1'b0;
    end else begin
      if (page_rx_in) begin
        lp_np_r <= page_word_in;
      end
      if (page_rx_in) begin
        page_flag_r <= 1'b1;
      end else if (rd_exp) begin
        page_flag_r <= 1'b0;
      end
    end
  end

  assign page_rx_flag_out = page_flag_r;

  // gigabit control; low byte is read-only zero whatever is written
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      ctrl_r <= `CTRL_RST;
    end else if (wr_now && ra == `RA_GB_CTRL) begin
      ctrl_r <= wr_word & `CTRL_WMASK;
    end
  end

  // reserved test codes run as normal mode instead of an undefined test
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      tm_r         <= `TM_NORMAL;
      cfg_master_r <= 1'b0;
    end else begin
      if (ctrl_r[`CTRL_TM_HI:`CTRL_TM_LO] > `TM_MAX) begin
        tm_r <= `TM_NORMAL;
      end else begin
        tm_r <= ctrl_r[`CTRL_TM_HI:`CTRL_TM_LO];
      end
      cfg_master_r <= ctrl_r[`CTRL_MS_MAN] & ctrl_r[`CTRL_MS_VAL];
    end
  end

  assign test_mode_out     = tm_r;
  assign ms_manual_out     = ctrl_r[`CTRL_MS_MAN];
  assign ms_cfg_master_out = cfg_master_r;
  assign port_multi_out    = ctrl_r[`CTRL_PORT];
  assign adv_1000fd_out    = ctrl_r[`CTRL_ADV_FD];
  assign adv_1000hd_out    = ctrl_r[`CTRL_ADV_HD];
  assign tech_ext_out      = ctrl_r[`CTRL_MS_MAN:`CTRL_ADV_HD];

  // fault latch: a fault in the clearing cycle keeps the bit set
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      fault_r <= 1'b0;
    end else if (ms_fault_in) begin
      fault_r <= 1'b1;
    end else if (rd_stat || an_complete_in || an_start_in) begin
      fault_r <= 1'b0;
    end
  end

  // live status, role, receivers and partner abilities, one cycle late
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      live_r <= 5'h00;
    end else begin
      live_r <= {ms_master_in, local_rx_ok_in, remote_rx_ok_in,
                 lp_1000fd_in, lp_1000hd_in};
    end
  end

  // idle error count; an error in the read cycle counts as the first new one
  assign idle_hit = idle_err_in & local_rx_ok_in & remote_rx_ok_in;
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      idle_cnt_r <= 8'h00;
    end else if (idle_hit) begin
      if (rd_stat) begin
        idle_cnt_r <= 8'h01;
      end else if (idle_cnt_r != `IDLE_MAX) begin
        idle_cnt_r <= idle_cnt_r + 8'h01;
      end
    end else if (rd_stat) begin
      idle_cnt_r <= 8'h00;
    end
  end

endmodule

// ### hw/gphy_sta_ctrl.sv
// station end: register port driving frames onto the management link
`timescale 1ns/1ps
`include "gphy_np_defines.svh"
module gphy_sta_ctrl
  import gphy_np_pkg::*;
#(
  parameter int MDC_HALF = 4,
  parameter int PREAMBLE = 32
) (
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  input  wire logic [1:0]  addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [15:0] rdata_out,
  mgmt_serial_if.sta_end   mgmt
);

  generate
    if (MDC_HALF < 2 || MDC_HALF > 255 || PREAMBLE < 1 || PREAMBLE > 63) begin : g_chk
      $error("MDC_HALF must be 2..255 and PREAMBLE 1..63");
    end
  endgenerate

  localparam logic [7:0] HALF_LAST = 8'(MDC_HALF - 1);
  localparam logic [5:0] PRE_LEN   = 6'(PREAMBLE);

  sta_state_t  state_r;
  logic [7:0]  div_r;
  logic        mdc_r;
  logic [5:0]  pre_r;
  logic [5:0]  idx_r;
  logic [31:0] frame_r;
  logic        is_rd_r;
  logic        h_out_r;
  logic        h_oe_r;
  logic [15:0] wdata_r;
  logic [15:0] rd_word_r;
  logic        done_r;
  logic [15:0] rdata_r;
  logic        tick;
  logic        start;
  logic        cmd_wr;
  logic [15:0] tx_data;

  assign tick   = (state_r != H_IDLE) && (div_r == HALF_LAST);
  assign cmd_wr = wdata_in[`CMD_WRITE];
  assign start  = wr_in && addr_in == `HA_CMD && state_r == H_IDLE;
  // reserved control low byte always goes out as zero
  assign tx_data = (wdata_in[4:0] == `RA_GB_CTRL) ? (wdata_r & `CTRL_WMASK) : wdata_r;

  // data register
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      wdata_r <= 16'h0000;
    end else if (wr_in && addr_in == `HA_WDATA) begin
      wdata_r <= wdata_in;
    end
  end

  // mdc divider runs only during a frame so the line idles low
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || state_r == H_IDLE) begin
      div_r <= 8'h00;
      mdc_r <= 1'b0;
    end else if (tick) begin
      div_r <= 8'h00;
      mdc_r <= ~mdc_r;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  // frame sequencer: change data on mdc fall, sample on mdc rise
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state_r   <= H_IDLE;
      pre_r     <= 6'h00;
      idx_r     <= 6'h00;
      frame_r   <= 32'h0000_0000;
      is_rd_r   <= 1'b0;
      h_out_r   <= 1'b1;
      h_oe_r    <= 1'b0;
      rd_word_r <= 16'h0000;
    end else if (start) begin
      state_r <= H_PRE;
      pre_r   <= 6'h00;
      idx_r   <= 6'h00;
      is_rd_r <= ~cmd_wr;
      h_out_r <= 1'b1;
      h_oe_r  <= 1'b1;
      frame_r <= {2'b01, cmd_wr ? `OP_WRITE : `OP_READ, wdata_in[9:0],
                  cmd_wr ? 2'b10 : 2'b11, cmd_wr ? tx_data : 16'hffff};
    end else if (tick && !mdc_r) begin
      if (state_r == H_FRAME && is_rd_r && idx_r >= `RD_SAMPLE) begin
        rd_word_r <= {rd_word_r[14:0], mgmt.mdio};
      end
    end else if (tick) begin
      unique case (state_r)
        H_PRE: begin
          if (pre_r == PRE_LEN) begin
            state_r <= H_FRAME;
            h_out_r <= frame_r[31];
            frame_r <= {frame_r[30:0], 1'b0};
          end else begin
            pre_r <= pre_r + 6'h01;
          end
        end
        H_FRAME: begin
          if (idx_r == `FRAME_LAST) begin
            state_r <= H_IDLE;
            h_oe_r  <= 1'b0;
            h_out_r <= 1'b1;
          end else begin
            idx_r   <= idx_r + 6'h01;
            h_out_r <= frame_r[31];
            frame_r <= {frame_r[30:0], 1'b0};
            h_oe_r  <= ~is_rd_r || (idx_r + 6'h01 < `RD_RELEASE);
          end
        end
        default: begin
          state_r <= H_IDLE;
        end
      endcase
    end
  end

  // completion flag; finishing in the read cycle keeps it set
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      done_r <= 1'b0;
    end else if (tick && mdc_r && state_r == H_FRAME && idx_r == `FRAME_LAST) begin
      done_r <= 1'b1;
    end else if (rd_in && addr_in == `HA_STAT) begin
      done_r <= 1'b0;
    end
  end

  // read data stands one cycle after the strobe
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      rdata_r <= 16'h0000;
    end else if (rd_in) begin
      unique case (addr_in)
        `HA_CMD:   rdata_r <= 16'h0000;
        `HA_WDATA: rdata_r <= wdata_r;
        `HA_RDATA: rdata_r <= rd_word_r;
        `HA_STAT:  rdata_r <= {14'h0000, done_r, state_r != H_IDLE};
      endcase
    end else begin
      rdata_r <= 16'h0000;
    end
  end

  assign rdata_out       = rdata_r;
  assign mgmt.mdc        = mdc_r;
  assign mgmt.mdio_h_out = h_out_r;
  assign mgmt.mdio_h_oe  = h_oe_r;

endmodule

// ### testbench/gphy_np_properties.sv
// concurrent checks on the management link and the phy end's register outputs
`timescale 1ns/1ps
module gphy_np_properties (
  input wire logic        clk_sys_in,
  input wire logic        reset_in,
  input wire logic        mdio_h_oe,
  input wire logic        mdio_d_oe,
  input wire logic [2:0]  test_mode_out,
  input wire logic        ms_manual_out,
  input wire logic        ms_cfg_master_out,
  input wire logic        port_multi_out,
  input wire logic        adv_1000fd_out,
  input wire logic        adv_1000hd_out,
  input wire logic [4:0]  tech_ext_out,
  input wire logic [15:0] np_tx_out,
  input wire logic        page_rx_flag_out,
  input wire logic        an_start_in,
  input wire logic        base_toggle_in,
  input wire logic        page_sent_in,
  input wire logic        page_rx_in
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  // a fight on the data line would corrupt every partner register read
  AST_ONE_DRIVER: assert property (!(mdio_h_oe && mdio_d_oe))
    else $error("both ends drive the data line");
  AST_NP_RESERVED: assert property (np_tx_out[14] == 1'b0)
    else $error("next page bit 14 not zero");
  AST_RESET_VALUES: assert property ($fell(reset_in) |-> np_tx_out == 16'h23ff
    && test_mode_out == 3'h0 && tech_ext_out == 5'h00 && !page_rx_flag_out)
    else $error("register outputs wrong at reset release");
  AST_TEST_MODE: assert property (test_mode_out <= 3'h4)
    else $error("reserved test mode reached the output");
  AST_ROLE_GATED: assert property (1'b1 |=>
    ms_cfg_master_out == $past(tech_ext_out[4] && tech_ext_out[3]))
    else $error("role value not gated by manual enable");
  AST_TECH_EXT: assert property (tech_ext_out == {ms_manual_out, tech_ext_out[3],
    port_multi_out, adv_1000fd_out, adv_1000hd_out})
    else $error("technology extension differs from control bits");
  AST_TOGGLE_LOAD: assert property (an_start_in |=>
    np_tx_out[11] == !$past(base_toggle_in))
    else $error("toggle not loaded from inverse of base page");
  AST_TOGGLE_FLIP: assert property (page_sent_in && !an_start_in |=>
    np_tx_out[11] != $past(np_tx_out[11]))
    else $error("toggle did not alternate");
  AST_PAGE_FLAG: assert property (page_rx_in |=> page_rx_flag_out)
    else $error("page received flag not set");
endmodule

// ### testbench/testbench.sv
// self-checking bench: station and phy ends joined over the management link
`timescale 1ns/1ps
module testbench;
  logic        clk_sys_in;
  logic        reset_in;
  logic [1:0]  addr_r;
  logic [15:0] wdata_r;
  logic        wr_r;
  logic        rd_r;
  logic [15:0] rdata;
  logic [5:0]  ev_r;   // fault, idle err, an done, an start, page sent, page rx
  logic [5:0]  lv_r;   // master, local ok, remote ok, lp fd, lp hd, base toggle
  logic [15:0] word_r;
  logic [2:0]  test_mode;
  logic        ms_manual;
  logic        ms_cfg_master;
  logic        port_multi;
  logic        adv_fd;
  logic        adv_hd;
  logic [4:0]  tech_ext;
  logic [15:0] np_tx;
  logic        page_flag;
  int          n_fail;
  int          samples_checked;

  mgmt_serial_if link ();
  // short preamble and fast management clock keep each frame near 140 cycles
  gphy_sta_ctrl #(.MDC_HALF(2), .PREAMBLE(1)) i_gphy_sta_ctrl (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .addr_in(addr_r), .wdata_in(wdata_r),
    .wr_in(wr_r), .rd_in(rd_r), .rdata_out(rdata), .mgmt(link));
  gphy_np_regs i_gphy_np_regs (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .mgmt(link),
    .ms_fault_in(ev_r[0]), .ms_master_in(lv_r[0]), .local_rx_ok_in(lv_r[1]),
    .remote_rx_ok_in(lv_r[2]), .lp_1000fd_in(lv_r[3]), .lp_1000hd_in(lv_r[4]),
    .idle_err_in(ev_r[1]), .an_complete_in(ev_r[2]), .an_start_in(ev_r[3]),
    .base_toggle_in(lv_r[5]), .page_sent_in(ev_r[4]), .page_rx_in(ev_r[5]),
    .page_word_in(word_r), .test_mode_out(test_mode), .ms_manual_out(ms_manual),
    .ms_cfg_master_out(ms_cfg_master), .port_multi_out(port_multi),
    .adv_1000fd_out(adv_fd), .adv_1000hd_out(adv_hd), .tech_ext_out(tech_ext),
    .np_tx_out(np_tx), .page_rx_flag_out(page_flag));
  gphy_np_properties i_props (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .mdio_h_oe(link.mdio_h_oe),
    .mdio_d_oe(link.mdio_d_oe), .test_mode_out(test_mode), .ms_manual_out(ms_manual),
    .ms_cfg_master_out(ms_cfg_master), .port_multi_out(port_multi),
    .adv_1000fd_out(adv_fd), .adv_1000hd_out(adv_hd), .tech_ext_out(tech_ext),
    .np_tx_out(np_tx), .page_rx_flag_out(page_flag), .an_start_in(ev_r[3]),
    .base_toggle_in(lv_r[5]), .page_sent_in(ev_r[4]), .page_rx_in(ev_r[5]));

  always #25 clk_sys_in = ~clk_sys_in;

  task automatic summarize;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one-cycle strobes; the trailing edge keeps a gap before the next call
  task automatic reg_wr(input logic [1:0] a, input logic [15:0] v);
    @(posedge clk_sys_in);
    addr_r <= a;
    wdata_r <= v;
    wr_r <= 1'b1;
    @(posedge clk_sys_in);
    wr_r <= 1'b0;
  endtask

  task automatic reg_rd(input logic [1:0] a, output logic [15:0] v);
    @(posedge clk_sys_in);
    addr_r <= a;
    rd_r <= 1'b1;
    @(posedge clk_sys_in);
    rd_r <= 1'b0;
    #1;
    v = rdata;
  endtask

  // polls the done flag; a frame that never ends closes the run
  task automatic wait_done;
    logic [15:0] s;
    s = 16'h0000;
    for (int i = 0; i < 400 && s[1] !== 1'b1; i++) begin
      reg_rd(2'h3, s);
    end
    if (s[1] !== 1'b1) begin
      n_fail++;
      summarize();
    end
  endtask

  task automatic phy_wr(input logic [4:0] r, input logic [15:0] v);
    reg_wr(2'h1, v);
    reg_wr(2'h0, {5'h00, 1'b1, 5'h01, r});
    wait_done();
  endtask

  task automatic rd_chk(input string nm, input logic [4:0] r, input logic [15:0] exp);
    logic [15:0] v;
    reg_wr(2'h0, {5'h00, 1'b0, 5'h01, r});
    wait_done();
    reg_rd(2'h2, v);
    chk(nm, v, exp);
  endtask

  task automatic pulse(input logic [5:0] m, input int n);
    @(posedge clk_sys_in);
    ev_r <= m;
    repeat (n) @(posedge clk_sys_in);
    ev_r <= 6'h00;
  endtask

  task automatic set_lv(input logic [5:0] v);
    @(posedge clk_sys_in);
    lv_r <= v;
  endtask

  task automatic do_reset;
    @(posedge clk_sys_in);
    reset_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    reset_in <= 1'b0;
  endtask

  initial begin
    clk_sys_in = 1'b0;
    reset_in = 1'b1;
    addr_r = 2'h0;
    wdata_r = 16'h0000;
    wr_r = 1'b0;
    rd_r = 1'b0;
    ev_r = 6'h00;
    lv_r = 6'h00;
    word_r = 16'hd5a5;
    n_fail = 0;
    samples_checked = 0;
    repeat (4) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    rd_chk("np_tx reset", 5'h07, 16'h23ff);
    rd_chk("partner np reset", 5'h08, 16'h0000);
    rd_chk("control reset", 5'h09, 16'h0000);
    rd_chk("status reset", 5'h0a, 16'h0000);
    // reserved bit and toggle must ignore a write of all ones
    phy_wr(5'h07, 16'hffff);
    rd_chk("np_tx ones", 5'h07, 16'hb7ff);
    chk("np_tx port", np_tx, 16'hb7ff);
    phy_wr(5'h07, 16'h0000);
    rd_chk("np_tx zeros", 5'h07, 16'h0000);
    pulse(6'h08, 1);
    rd_chk("toggle loaded", 5'h07, 16'h0800);
    pulse(6'h10, 1);
    rd_chk("toggle flipped", 5'h07, 16'h0000);
    // received page is read-only; the flag clears on its own read
    pulse(6'h20, 1);
    phy_wr(5'h08, 16'hffff);
    rd_chk("partner np", 5'h08, 16'hd5a5);
    rd_chk("page flag set", 5'h06, 16'h0002);
    rd_chk("page flag clear", 5'h06, 16'h0000);
    for (int t = 0; t < 8; t++) begin
      phy_wr(5'h09, {t[2:0], 13'h0000});
      rd_chk("test mode reg", 5'h09, {t[2:0], 13'h0000});
      chk("test mode out", {13'h0000, test_mode}, (t < 5) ? {13'h0000, t[2:0]} : 16'h0000);
    end
    phy_wr(5'h09, 16'h0800);
    chk("role ignored", {15'h0000, ms_cfg_master}, 16'h0000);
    phy_wr(5'h09, 16'h1800);
    chk("role manual", {14'h0000, ms_manual, ms_cfg_master}, 16'h0003);
    phy_wr(5'h09, 16'h1fff);
    rd_chk("control low byte", 5'h09, 16'h1f00);
    chk("tech ext", {11'h000, tech_ext}, 16'h001f);
    chk("adverts", {13'h0000, port_multi, adv_fd, adv_hd}, 16'h0007);
    // fault latch plus three back-to-back idle errors
    set_lv(6'b001111);
    pulse(6'h01, 1);
    pulse(6'h02, 3);
    rd_chk("status full", 5'h0a, 16'hf803);
    rd_chk("status after read", 5'h0a, 16'h7800);
    pulse(6'h01, 1);
    pulse(6'h04, 1);
    rd_chk("fault cleared by done", 5'h0a, 16'h7800);
    set_lv(6'b010101);
    pulse(6'h02, 2);
    rd_chk("count gated", 5'h0a, 16'h5400);
    set_lv(6'b000111);
    pulse(6'h02, 300);
    rd_chk("count saturates", 5'h0a, 16'h70ff);
    pulse(6'h02, 5);
    do_reset();
    rd_chk("count after reset", 5'h0a, 16'h7000);
    rd_chk("np_tx after reset", 5'h07, 16'h23ff);
    summarize();
  end
endmodule
